// file: rtl/slpc_defs.vh
// Register indices, field positions, reset values and bus codes of the link capture block.
`ifndef SLPC_DEFS_VH
`define SLPC_DEFS_VH

// Register indices; the byte address is four times the index.
`define SLPC_IDX_W 12
`define SLPC_IDX_CHECK_CTRL 12'h32c
`define SLPC_IDX_REF_LOW 12'h32d
`define SLPC_IDX_REF_HIGH 12'h32e
`define SLPC_IDX_CHECK_RESULT 12'h32f
`define SLPC_IDX_RX_CONFIG 12'h333
`define SLPC_IDX_LANE_INVERT 12'h334
`define SLPC_IDX_DEVICE_IDENT 12'h400
`define SLPC_IDX_BANK_ADJUST 12'h401
`define SLPC_IDX_LANE_IDENT 12'h402
`define SLPC_IDX_SCRAMBLE_LANES 12'h403
`define SLPC_IDX_OCTETS 12'h404
`define SLPC_IDX_FRAMES 12'h405
`define SLPC_IDX_INT_STATUS 12'h500
`define SLPC_IDX_INT_MASK 12'h501
`define SLPC_IDX_NONE 12'hfff

// Check control fields.
`define SLPC_CTRL_ENABLE 0
`define SLPC_CTRL_CLEAR 1
`define SLPC_CTRL_CONV_LSB 2
`define SLPC_CTRL_SAMPLE_LSB 4
`define SLPC_CTRL_MASK 8'h3f
`define SLPC_SAMPLE_NONE 2'h3

// Field positions of the captured link registers.
`define SLPC_ADJ_DIR_BIT 6
`define SLPC_PHASE_ADJ_BIT 5
`define SLPC_SCRAMBLE_BIT 7

// Interrupt status bits.
`define SLPC_INT_CHECK_FAIL 0
`define SLPC_INT_CAPTURED 1
`define SLPC_INT_W 2

// Reset values.
`define SLPC_RESET_BYTE 8'h00

// AXI response codes.
`define SLPC_RESP_OKAY 2'h0
`define SLPC_RESP_SLVERR 2'h2

`endif

// file: rtl/slpc_top.v
// Link status and control registers with lane-0 parameter capture, behind an AXI4-Lite slave.
`timescale 1ns/100ps
`include "slpc_defs.vh"
module slpc_top #(
   parameter ADDR_W = 14,
   parameter LANES = 8,
   parameter LANE_W = 40,
   parameter CONVS = 4,
   parameter SAMPLES_PER_CONV = 3,
   parameter SAMPLE_W = 16
) (
   // Clock and reset.
   input wire CLK,
   input wire RESET,
   // AXI4-Lite write address.
   input wire AWVALID,
   output wire AWREADY,
   input wire [ADDR_W-1:0] AWADDR,
   input wire [2:0] AWPROT,
   // AXI4-Lite write data.
   input wire WVALID,
   output wire WREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   // AXI4-Lite write response.
   output reg BVALID,
   input wire BREADY,
   output reg [1:0] BRESP,
   // AXI4-Lite read address.
   input wire ARVALID,
   output wire ARREADY,
   input wire [ADDR_W-1:0] ARADDR,
   input wire [2:0] ARPROT,
   // AXI4-Lite read data.
   output reg RVALID,
   input wire RREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   // Interrupt.
   output wire IRQ,
   // Deserialized lane data in and after inversion.
   input wire [LANES*LANE_W-1:0] LANE_DATA_IN,
   output reg [LANES*LANE_W-1:0] LANE_DATA_OUT,
   // Receiver output samples and their qualifier.
   input wire SAMPLE_VALID,
   input wire [CONVS*SAMPLES_PER_CONV*SAMPLE_W-1:0] SAMPLE_DATA,
   // Lane-0 configuration fields and capture strobe.
   input wire CFG_VALID,
   input wire [7:0] CFG_DEVICE_IDENT,
   input wire [3:0] CFG_BANK_IDENT,
   input wire [3:0] CFG_ADJUST_STEP_COUNT,
   input wire CFG_ADJUST_DIRECTION,
   input wire CFG_PHASE_ADJUST_REQUEST,
   input wire [4:0] CFG_LANE_IDENT,
   input wire CFG_SCRAMBLE_FLAG,
   input wire [4:0] CFG_LANE_COUNT,
   input wire [7:0] CFG_OCTETS_PER_FRAME,
   input wire [4:0] CFG_FRAMES_PER_MULTIFRAME,
   // Receiver configuration word for the link receiver.
   output wire [7:0] RX_CONFIG_WORD
);

   localparam IW = `SLPC_IDX_W;

   // Maps a byte address to a register index, or to the unmapped index.
   function [IW-1:0] slpc_index;
      input [ADDR_W-1:0] addr;
      reg [IW-1:0] idx;
      begin
         idx = addr[IW+1:2];
         slpc_index = `SLPC_IDX_NONE;
         if (addr[1:0] == 2'h0) begin
            case (idx)
               `SLPC_IDX_CHECK_CTRL, `SLPC_IDX_REF_LOW, `SLPC_IDX_REF_HIGH,
               `SLPC_IDX_CHECK_RESULT, `SLPC_IDX_RX_CONFIG, `SLPC_IDX_LANE_INVERT,
               `SLPC_IDX_DEVICE_IDENT, `SLPC_IDX_BANK_ADJUST, `SLPC_IDX_LANE_IDENT,
               `SLPC_IDX_SCRAMBLE_LANES, `SLPC_IDX_OCTETS, `SLPC_IDX_FRAMES,
               `SLPC_IDX_INT_STATUS, `SLPC_IDX_INT_MASK: slpc_index = idx;
               default: slpc_index = `SLPC_IDX_NONE;
            endcase
         end
      end
   endfunction

   // Software registers.
   reg [7:0] check_ctrl;
   reg [7:0] ref_sample_low;
   reg [7:0] ref_sample_high;
   reg [7:0] rx_config;
   reg [7:0] lane_invert_mask;
   reg [`SLPC_INT_W-1:0] int_mask;
   reg [`SLPC_INT_W-1:0] int_status;
   reg sample_check_fail;

   // Captured lane-0 parameters.
   reg [7:0] rx_device_ident;
   reg [3:0] rx_bank_ident;
   reg [3:0] rx_adjust_step_count;
   reg rx_adjust_direction;
   reg rx_phase_adjust_request;
   reg [4:0] rx_lane_ident;
   reg rx_scramble_flag;
   reg [4:0] rx_lane_count;
   reg [7:0] rx_octets_per_frame;
   reg [4:0] rx_frames_per_multiframe;

   // Write channel holding state.
   reg aw_held;
   reg [ADDR_W-1:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire aw_hs = AWVALID & AWREADY;
   wire w_hs = WVALID & WREADY;
   wire ar_hs = ARVALID & ARREADY;
   assign AWREADY = ~aw_held & ~BVALID;
   assign WREADY = ~w_held & ~BVALID;
   assign ARREADY = ~RVALID;

   wire have_aw = aw_held | aw_hs;
   wire have_w = w_held | w_hs;
   wire do_write = have_aw & have_w & ~BVALID;
   wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : AWADDR;
   wire [31:0] wr_data = w_held ? w_data : WDATA;
   wire [3:0] wr_strb = w_held ? w_strb : WSTRB;
   wire [IW-1:0] wr_idx = slpc_index(wr_addr);
   wire wr_lane0 = do_write & wr_strb[0];
   wire [IW-1:0] rd_idx = slpc_index(ARADDR);

   // Sample check datapath.
   wire check_enable = check_ctrl[`SLPC_CTRL_ENABLE];
   wire check_result_clear = check_ctrl[`SLPC_CTRL_CLEAR];
   wire [1:0] check_converter_select = check_ctrl[`SLPC_CTRL_CONV_LSB+1:`SLPC_CTRL_CONV_LSB];
   wire [1:0] check_sample_select = check_ctrl[`SLPC_CTRL_SAMPLE_LSB+1:`SLPC_CTRL_SAMPLE_LSB];
   wire [3:0] sel_slot = {1'b0, check_converter_select, 1'b0} + {2'h0, check_converter_select}
      + {2'h0, check_sample_select};
   wire [SAMPLE_W-1:0] chosen_sample = SAMPLE_DATA[sel_slot*SAMPLE_W +: SAMPLE_W];
   wire [15:0] ref_sample = {ref_sample_high, ref_sample_low};
   // Sample select 3 names no sample, so it keeps the compare idle.
   wire check_mismatch = check_enable & SAMPLE_VALID
      & (check_sample_select != `SLPC_SAMPLE_NONE)
      & (chosen_sample != ref_sample);

   // Events that set the sticky interrupt status.
   wire [`SLPC_INT_W-1:0] int_event;
   assign int_event[`SLPC_INT_CHECK_FAIL] = check_mismatch & ~sample_check_fail;
   assign int_event[`SLPC_INT_CAPTURED] = CFG_VALID;
   assign IRQ = |(int_status & int_mask);
   assign RX_CONFIG_WORD = rx_config;

   // Lane inversion, one register stage per lane.
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         always @(posedge CLK) begin
            if (RESET) begin
               LANE_DATA_OUT[g*LANE_W +: LANE_W] <= {LANE_W{1'b0}};
            end else begin
               LANE_DATA_OUT[g*LANE_W +: LANE_W] <= LANE_DATA_IN[g*LANE_W +: LANE_W]
                  ^ {LANE_W{lane_invert_mask[g]}};
            end
         end
      end
   endgenerate

   // Software-written registers and write response.
   always @(posedge CLK) begin
      if (RESET) begin
         check_ctrl <= `SLPC_RESET_BYTE;
         ref_sample_low <= `SLPC_RESET_BYTE;
         ref_sample_high <= `SLPC_RESET_BYTE;
         rx_config <= `SLPC_RESET_BYTE;
         lane_invert_mask <= `SLPC_RESET_BYTE;
         int_mask <= {`SLPC_INT_W{1'b0}};
         aw_held <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= `SLPC_RESP_OKAY;
      end else begin
         if (aw_hs & ~do_write) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (w_hs & ~do_write) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= (wr_idx == `SLPC_IDX_NONE) ? `SLPC_RESP_SLVERR : `SLPC_RESP_OKAY;
         end else if (BVALID & BREADY) begin
            BVALID <= 1'b0;
         end
         if (wr_lane0) begin
            case (wr_idx)
               `SLPC_IDX_CHECK_CTRL: check_ctrl <= wr_data[7:0] & `SLPC_CTRL_MASK;
               `SLPC_IDX_REF_LOW: ref_sample_low <= wr_data[7:0];
               `SLPC_IDX_REF_HIGH: ref_sample_high <= wr_data[7:0];
               `SLPC_IDX_RX_CONFIG: rx_config <= wr_data[7:0];
               `SLPC_IDX_LANE_INVERT: lane_invert_mask <= wr_data[7:0];
               `SLPC_IDX_INT_MASK: int_mask <= wr_data[`SLPC_INT_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Sample check result and sticky interrupt status.
   always @(posedge CLK) begin
      if (RESET) begin
         sample_check_fail <= 1'b0;
         int_status <= {`SLPC_INT_W{1'b0}};
      end else begin
         if (check_mismatch) begin
            sample_check_fail <= 1'b1;
         end else if (check_result_clear) begin
            sample_check_fail <= 1'b0;
         end
         // A read clears the status, but an event in the same cycle is not lost.
         if (ar_hs & (rd_idx == `SLPC_IDX_INT_STATUS)) begin
            int_status <= int_event;
         end else begin
            int_status <= int_status | int_event;
         end
      end
   end

   // Capture of lane-0 link parameters.
   always @(posedge CLK) begin
      if (RESET) begin
         rx_device_ident <= 8'h00;
         rx_bank_ident <= 4'h0;
         rx_adjust_step_count <= 4'h0;
         rx_adjust_direction <= 1'b0;
         rx_phase_adjust_request <= 1'b0;
         rx_lane_ident <= 5'h00;
         rx_scramble_flag <= 1'b0;
         rx_lane_count <= 5'h00;
         rx_octets_per_frame <= 8'h00;
         rx_frames_per_multiframe <= 5'h00;
      end else if (CFG_VALID) begin
         rx_device_ident <= CFG_DEVICE_IDENT;
         rx_bank_ident <= CFG_BANK_IDENT;
         rx_adjust_step_count <= CFG_ADJUST_STEP_COUNT;
         rx_adjust_direction <= CFG_ADJUST_DIRECTION;
         rx_phase_adjust_request <= CFG_PHASE_ADJUST_REQUEST;
         rx_lane_ident <= CFG_LANE_IDENT;
         rx_scramble_flag <= CFG_SCRAMBLE_FLAG;
         rx_lane_count <= CFG_LANE_COUNT;
         rx_octets_per_frame <= CFG_OCTETS_PER_FRAME;
         rx_frames_per_multiframe <= CFG_FRAMES_PER_MULTIFRAME;
      end
   end

   // Read data multiplexer.
   reg [7:0] rd_val;
   always @* begin
      rd_val = 8'h00;
      case (rd_idx)
         `SLPC_IDX_CHECK_CTRL: rd_val = check_ctrl;
         `SLPC_IDX_REF_LOW: rd_val = ref_sample_low;
         `SLPC_IDX_REF_HIGH: rd_val = ref_sample_high;
         `SLPC_IDX_CHECK_RESULT: rd_val = {7'h00, sample_check_fail};
         `SLPC_IDX_RX_CONFIG: rd_val = rx_config;
         `SLPC_IDX_LANE_INVERT: rd_val = lane_invert_mask;
         `SLPC_IDX_DEVICE_IDENT: rd_val = rx_device_ident;
         `SLPC_IDX_BANK_ADJUST: rd_val = {rx_adjust_step_count, rx_bank_ident};
         `SLPC_IDX_LANE_IDENT: rd_val = {1'b0, rx_adjust_direction,
            rx_phase_adjust_request, rx_lane_ident};
         `SLPC_IDX_SCRAMBLE_LANES: rd_val = {rx_scramble_flag, 2'h0, rx_lane_count};
         `SLPC_IDX_OCTETS: rd_val = rx_octets_per_frame;
         `SLPC_IDX_FRAMES: rd_val = {3'h0, rx_frames_per_multiframe};
         `SLPC_IDX_INT_STATUS: rd_val = {{(8-`SLPC_INT_W){1'b0}}, int_status};
         `SLPC_IDX_INT_MASK: rd_val = {{(8-`SLPC_INT_W){1'b0}}, int_mask};
         default: rd_val = 8'h00;
      endcase
   end

   // Read response.
   always @(posedge CLK) begin
      if (RESET) begin
         RVALID <= 1'b0;
         RDATA <= 32'h0;
         RRESP <= `SLPC_RESP_OKAY;
      end else if (ar_hs) begin
         RVALID <= 1'b1;
         RDATA <= {24'h0, rd_val};
         RRESP <= (rd_idx == `SLPC_IDX_NONE) ? `SLPC_RESP_SLVERR : `SLPC_RESP_OKAY;
      end else if (RVALID & RREADY) begin
         RVALID <= 1'b0;
      end
   end

endmodule

// file: tb/slpc_checker.sv
// Concurrent checks on the ports of the link capture block.
`timescale 1ns/100ps
module slpc_checker #(
   parameter LANES = 8,
   parameter LANE_W = 40
) (
   // Clock and reset.
   input wire CLK,
   input wire RESET,
   // Register bus.
   input wire AWVALID,
   input wire AWREADY,
   input wire WVALID,
   input wire WREADY,
   input wire BVALID,
   input wire BREADY,
   input wire [1:0] BRESP,
   input wire ARVALID,
   input wire ARREADY,
   input wire RVALID,
   input wire RREADY,
   input wire [31:0] RDATA,
   // Events, lanes and configuration.
   input wire IRQ,
   input wire SAMPLE_VALID,
   input wire CFG_VALID,
   input wire [LANES*LANE_W-1:0] LANE_DATA_IN,
   input wire [LANES*LANE_W-1:0] LANE_DATA_OUT,
   input wire [7:0] RX_CONFIG_WORD
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   write_answer_a: assert property (
      AWVALID && AWREADY && WVALID && WREADY |=> BVALID) else $error("no write answer");
   bresp_hold_a: assert property (
      BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
   read_answer_a: assert property (
      ARVALID && ARREADY |=> RVALID) else $error("no read answer");
   rdata_hold_a: assert property (
      RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read answer dropped");
   write_refused_a: assert property (
      BVALID |-> !AWREADY && !WREADY) else $error("write taken during answer");
   read_refused_a: assert property (
      RVALID |-> !ARREADY) else $error("read taken during answer");
   rdata_upper_a: assert property (
      RVALID |-> RDATA[31:8] == 24'h0) else $error("upper read bits set");
   lane_invert_a: assert property (
      !$past(RESET) |-> ($past(LANE_DATA_IN[LANE_W-1:0]) ^ LANE_DATA_OUT[LANE_W-1:0])
      inside {{LANE_W{1'b0}}, {LANE_W{1'b1}}}) else $error("lane 0 not whole inverted");
   irq_rise_a: assert property (
      $rose(IRQ) |-> $rose(BVALID) || $past(CFG_VALID || SAMPLE_VALID))
      else $error("interrupt without event");
   irq_fall_a: assert property (
      $fell(IRQ) |-> $rose(BVALID) || $rose(RVALID)) else $error("interrupt fell alone");
   rx_config_a: assert property (
      $changed(RX_CONFIG_WORD) |-> BVALID || $past(BVALID)) else $error("config word moved");
   cover property (BVALID && BRESP == 2'h2);
   cover property ($rose(IRQ));
   cover property (CFG_VALID ##2 RVALID);
endmodule
bind slpc_top slpc_checker #(.LANES(LANES), .LANE_W(LANE_W)) i_slpc_checker (.*);

// file: tb/slpc_partner.sv
// Model of the transmitting side: lane-0 parameters and receiver samples.
`timescale 1ns/100ps
module slpc_partner (
   // Clock.
   input wire clk,
   // Lane-0 parameter fields and strobe.
   output reg cfg_valid,
   output reg [41:0] cfg,
   // Receiver samples.
   output reg sample_valid,
   output reg [191:0] sample_data
);
   initial begin
      cfg_valid = 1'b0;
      cfg = 42'h0;
      sample_valid = 1'b0;
      sample_data = 192'h0;
   end
   // Sends one parameter set; the fields are scrambled once the strobe is gone.
   task send(input [41:0] f);
      begin
         cfg <= f;
         cfg_valid <= 1'b1;
         @(posedge clk);
         cfg_valid <= 1'b0;
         cfg <= ~f;
      end
   endtask
   // Presents one sample set with value v in one slot and its inverse elsewhere.
   task smp(input [3:0] slot, input [15:0] v);
      reg [191:0] s;
      begin
         s = {12{~v}};
         s[slot*16 +: 16] = v;
         sample_data <= s;
         sample_valid <= 1'b1;
         @(posedge clk);
         sample_valid <= 1'b0;
         sample_data <= ~s;
      end
   endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the link capture register block.
`timescale 1ns/100ps
`include "slpc_defs.vh"
module tb;
   reg CLK = 1'b0;
   reg RESET = 1'b1;
   reg AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   reg [13:0] AWADDR = 14'h0, ARADDR = 14'h0;
   reg [31:0] WDATA = 32'h0;
   reg [3:0] WSTRB = 4'hf;
   reg [319:0] LANE_DATA_IN = 320'h0;
   reg [41:0] f;
   wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SAMPLE_VALID, CFG_VALID;
   wire [1:0] BRESP, RRESP;
   wire [31:0] RDATA;
   wire [319:0] LANE_DATA_OUT;
   wire [191:0] SAMPLE_DATA;
   wire [41:0] cfg;
   wire [7:0] RX_CONFIG_WORD;
   integer n_mismatch = 0, checks = 0, i, hold = 0;
   always #25 CLK = ~CLK;
   slpc_top i_slpc_top (.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
      .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY),
      .RDATA(RDATA), .RRESP(RRESP), .IRQ(IRQ), .LANE_DATA_IN(LANE_DATA_IN),
      .LANE_DATA_OUT(LANE_DATA_OUT), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA),
      .CFG_VALID(CFG_VALID), .CFG_DEVICE_IDENT(cfg[41:34]), .CFG_BANK_IDENT(cfg[33:30]),
      .CFG_ADJUST_STEP_COUNT(cfg[29:26]), .CFG_ADJUST_DIRECTION(cfg[25]),
      .CFG_PHASE_ADJUST_REQUEST(cfg[24]), .CFG_LANE_IDENT(cfg[23:19]),
      .CFG_SCRAMBLE_FLAG(cfg[18]), .CFG_LANE_COUNT(cfg[17:13]),
      .CFG_OCTETS_PER_FRAME(cfg[12:5]), .CFG_FRAMES_PER_MULTIFRAME(cfg[4:0]),
      .RX_CONFIG_WORD(RX_CONFIG_WORD));
   slpc_partner i_slpc_partner (.clk(CLK), .cfg_valid(CFG_VALID), .cfg(cfg),
      .sample_valid(SAMPLE_VALID), .sample_data(SAMPLE_DATA));
   task chk(input [31:0] g, input [31:0] x);
      begin
         checks = checks + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task wr(input [11:0] a, input [7:0] d, input [1:0] r);
      reg aw, w;
      begin
         aw = 1'b1;
         w = 1'b1;
         AWADDR <= {a, 2'b00};
         WDATA <= {24'h0, d};
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         while (aw || w) begin
            @(posedge CLK);
            if (aw && AWREADY) begin
               aw = 1'b0;
               AWVALID <= 1'b0;
            end
            if (w && WREADY) begin
               w = 1'b0;
               WVALID <= 1'b0;
            end
         end
         repeat (hold) @(posedge CLK);
         BREADY <= 1'b1;
         do @(posedge CLK); while (!BVALID);
         chk(BRESP, r);
         BREADY <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [7:0] x, input [1:0] r);
      begin
         ARADDR <= {a, 2'b00};
         ARVALID <= 1'b1;
         do @(posedge CLK); while (!ARREADY);
         ARVALID <= 1'b0;
         repeat (hold) @(posedge CLK);
         RREADY <= 1'b1;
         do @(posedge CLK); while (!RVALID);
         chk(RDATA, {24'h0, x});
         chk(RRESP, r);
         RREADY <= 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (5000) @(posedge CLK);
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: watchdog expired", $time);
      final_report;
   end
   initial begin
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
         rd(`SLPC_IDX_DEVICE_IDENT + i[11:0], 8'h00, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_CHECK_RESULT, 8'h00, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_LANE_INVERT, 8'h00, `SLPC_RESP_OKAY);
      $display("test 1 done");
      hold = 2;
      wr(`SLPC_IDX_RX_CONFIG, 8'h01, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_RX_CONFIG, 8'h01, `SLPC_RESP_OKAY);
      hold = 0;
      WSTRB <= 4'he;
      wr(`SLPC_IDX_RX_CONFIG, 8'h00, `SLPC_RESP_OKAY);
      WSTRB <= 4'hf;
      rd(`SLPC_IDX_RX_CONFIG, 8'h01, `SLPC_RESP_OKAY);
      chk({24'h0, RX_CONFIG_WORD}, 32'h1);
      wr(`SLPC_IDX_LANE_INVERT, 8'ha5, `SLPC_RESP_OKAY);
      LANE_DATA_IN <= {8{40'h123456789a}};
      repeat (2) @(posedge CLK);
      for (i = 0; i < 8; i = i + 1)
         chk(LANE_DATA_OUT[i*40 +: 32], (8'ha5 >> i) & 1 ? ~32'h3456789a : 32'h3456789a);
      wr(`SLPC_IDX_CHECK_CTRL, 8'hff, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_CHECK_CTRL, 8'h3f, `SLPC_RESP_OKAY);
      wr(`SLPC_IDX_DEVICE_IDENT, 8'h55, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_DEVICE_IDENT, 8'h00, `SLPC_RESP_OKAY);
      wr(`SLPC_IDX_NONE, 8'h55, `SLPC_RESP_SLVERR);
      rd(`SLPC_IDX_NONE, 8'h00, `SLPC_RESP_SLVERR);
      $display("test 2 done");
      for (i = 0; i < 2; i = i + 1) begin
         f = i ? {8'h5a, 4'ha, 4'h3, 2'b01, 5'h0c, 1'b0, 5'd1, 8'd1, 5'h0f}
               : {8'ha7, 4'h5, 4'hc, 2'b10, 5'h13, 1'b1, 5'd3, 8'd3, 5'h1f};
         i_slpc_partner.send(f);
         rd(`SLPC_IDX_DEVICE_IDENT, f[41:34], `SLPC_RESP_OKAY);
         rd(`SLPC_IDX_BANK_ADJUST, {f[29:26], f[33:30]}, `SLPC_RESP_OKAY);
         rd(`SLPC_IDX_LANE_IDENT, {1'b0, f[25:19]}, `SLPC_RESP_OKAY);
         rd(`SLPC_IDX_SCRAMBLE_LANES, {f[18], 2'b0, f[17:13]}, `SLPC_RESP_OKAY);
         rd(`SLPC_IDX_OCTETS, f[12:5], `SLPC_RESP_OKAY);
         rd(`SLPC_IDX_FRAMES, {3'b0, f[4:0]}, `SLPC_RESP_OKAY);
      end
      chk({31'h0, IRQ}, 32'h0);
      wr(`SLPC_IDX_INT_MASK, 8'h03, `SLPC_RESP_OKAY);
      chk({31'h0, IRQ}, 32'h1);
      rd(`SLPC_IDX_INT_STATUS, 8'h02, `SLPC_RESP_OKAY);
      chk({31'h0, IRQ}, 32'h0);
      $display("test 3 done");
      wr(`SLPC_IDX_REF_LOW, 8'h34, `SLPC_RESP_OKAY);
      wr(`SLPC_IDX_REF_HIGH, 8'h12, `SLPC_RESP_OKAY);
      wr(`SLPC_IDX_CHECK_CTRL, 8'h19, `SLPC_RESP_OKAY);
      i_slpc_partner.smp(4'd7, 16'h1234);
      rd(`SLPC_IDX_CHECK_RESULT, 8'h00, `SLPC_RESP_OKAY);
      i_slpc_partner.smp(4'd7, 16'h1235);
      rd(`SLPC_IDX_CHECK_RESULT, 8'h01, `SLPC_RESP_OKAY);
      rd(`SLPC_IDX_INT_STATUS, 8'h01, `SLPC_RESP_OKAY);
      wr(`SLPC_IDX_CHECK_CTRL, 8'h1a, `SLPC_RESP_OKAY);
      i_slpc_partner.smp(4'd7, 16'h1235);
      rd(`SLPC_IDX_CHECK_RESULT, 8'h00, `SLPC_RESP_OKAY);
      $display("test 4 done");
      final_report;
   end
endmodule
